// ---- core/qgpt_channel.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// one timer channel
// ----------------------------------------
module qgpt_channel #(
    parameter bit HAS_EXT = 1'b1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic div16_tick,
    input wire logic [qgpt_pkg::MC_W-1:0] mode_config,
    input wire logic [qgpt_pkg::CNT_W-1:0] reference_value,
    input wire logic ext_in,
    input wire logic cap_in,
    input wire logic [qgpt_pkg::EV_W-1:0] event_clear,
    output logic [qgpt_pkg::CNT_W-1:0] count_value,
    output logic [qgpt_pkg::CNT_W-1:0] capture_value,
    output logic [qgpt_pkg::EV_W-1:0] event_flags,
    output logic irq,
    output logic cmp_out
);
    import qgpt_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic ext_s1_ff, ext_s2_ff, ext_s3_ff;   // sync chain plus edge history
    logic cap_prev_ff;                       // capture pin history
    logic [PRE_W-1:0] pre_ff;                // prescaler count
    logic [CNT_W-1:0] cnt_ff;                // counter
    logic [CNT_W-1:0] cap_ff;                // capture register
    logic [EV_W-1:0] ev_ff;                  // event flags
    logic match_ff;                          // match seen, restart pending
    logic out_ff;                            // compare output
    logic src_tick, pre_tick, match, cap_hit;
    logic en;
    logic [1:0] clk_sel, cap_edge;
    logic [PRE_W-1:0] pre_max;

    assign en = mode_config[MC_RST_POS];
    assign clk_sel = mode_config[MC_CLK_LSB +: 2];
    assign cap_edge = mode_config[MC_CE_LSB +: 2];
    assign pre_max = mode_config[MC_PS_LSB +: PRE_W];

    // ----------------------------------------
    // external input synchroniser
    // ----------------------------------------
    // third stage only for edge detect, so stage one feeds stage two alone
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end else begin
            ext_s1_ff <= ext_in;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end

    // source tick selection; ext only exists on channels 0 and 1
    always_comb begin
        case (clk_sel)
            CLK_DIV1: src_tick = 1'b1;
            CLK_DIV16: src_tick = div16_tick;
            CLK_EXT: src_tick = HAS_EXT && ext_s2_ff && !ext_s3_ff;
            default: src_tick = 1'b0;
        endcase
    end

    // ----------------------------------------
    // prescaler: divides by pre_max + 1, up to 2^8
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_ff <= '0;
        end else if (!en) begin
            pre_ff <= '0;
        end else if (src_tick) begin
            pre_ff <= (pre_ff == pre_max) ? '0 : pre_ff + 8'h01;
        end
    end
    assign pre_tick = en && src_tick && (pre_ff == pre_max);

    // ----------------------------------------
    // counter with restart or free run
    // ----------------------------------------
    assign match = en && (cnt_ff == reference_value) && !match_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= CNT_RESET;
            match_ff <= 1'b0;
        end else if (!en) begin
            cnt_ff <= CNT_RESET;
            match_ff <= 1'b0;
        end else begin
            // a tick in the match cycle consumes the match at once
            if (pre_tick) begin
                match_ff <= 1'b0;
            end else if (match) begin
                match_ff <= 1'b1;
            end
            if (pre_tick) begin
                // restart: the tick that leaves the reference returns to zero
                if ((match || match_ff) && mode_config[MC_FRR_POS]) begin
                    cnt_ff <= CNT_RESET;
                end else begin
                    cnt_ff <= cnt_ff + 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------
    // capture on selected pin edge
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cap_prev_ff <= 1'b0;
        end else begin
            cap_prev_ff <= cap_in;
        end
    end
    always_comb begin
        case (cap_edge)
            CE_RISE: cap_hit = cap_in && !cap_prev_ff;
            CE_FALL: cap_hit = !cap_in && cap_prev_ff;
            CE_ANY: cap_hit = cap_in ^ cap_prev_ff;
            default: cap_hit = 1'b0;
        endcase
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cap_ff <= CNT_RESET;
        end else if (en && cap_hit) begin
            cap_ff <= cnt_ff;
        end
    end

    // ----------------------------------------
    // event flags: set wins over clear
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ev_ff <= '0;
        end else begin
            ev_ff[EV_CAP] <= (en && cap_hit) || (ev_ff[EV_CAP] && !event_clear[EV_CAP]);
            ev_ff[EV_REF] <= match || (ev_ff[EV_REF] && !event_clear[EV_REF]);
        end
    end

    // ----------------------------------------
    // output compare: pulse or toggle
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_ff <= 1'b0;
        end else if (mode_config[MC_OM_POS]) begin
            if (match) out_ff <= !out_ff;
        end else begin
            out_ff <= match;
        end
    end

    assign count_value = cnt_ff;
    assign capture_value = cap_ff;
    assign event_flags = ev_ff;
    assign irq = ev_ff[EV_REF] && mode_config[MC_ORI_POS];
    assign cmp_out = out_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_REF_FLAG: assert property (@(posedge mclk) disable iff (!rst_n)
        match |=> ev_ff[EV_REF]) else $error("reference flag not set");
    AST_CAP_COPY: assert property (@(posedge mclk) disable iff (!rst_n)
        (en && cap_hit) |=> (cap_ff == $past(cnt_ff)) && ev_ff[EV_CAP])
        else $error("capture missed");
    AST_RESTART: assert property (@(posedge mclk) disable iff (!rst_n)
        (en && (match || match_ff) && pre_tick && mode_config[MC_FRR_POS]) |=>
        cnt_ff == 16'h0000)
        else $error("restart did not clear count");
    AST_NO_EXT: assert property (@(posedge mclk) disable iff (!rst_n)
        (!HAS_EXT && clk_sel == CLK_EXT) |-> !src_tick) else $error("ext on ch2/3");
    AST_SYNC: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(ext_s2_ff) |-> $past(ext_in, 2)) else $error("sync delay wrong");
    AST_COUNT: assert property (@(posedge mclk) disable iff (!rst_n)
        (en && !pre_tick) |=> cnt_ff == $past(cnt_ff)) else $error("count moved");
    AST_IRQ: assert property (@(posedge mclk) disable iff (!rst_n)
        (match && mode_config[MC_ORI_POS]) ##1 mode_config[MC_ORI_POS] |-> irq)
        else $error("irq missing");
    AST_DIV1: assert property (@(posedge mclk) disable iff (!rst_n)
        (en && clk_sel == CLK_DIV1 && pre_max == 8'h00 && !match_ff &&
        !(match && mode_config[MC_FRR_POS])) |=>
        cnt_ff == $past(cnt_ff) + 16'h0001) else $error("div1 not every clock");
    COV_MATCH: cover property (@(posedge mclk) match);
    COV_CAP: cover property (@(posedge mclk) en && cap_hit);
    COV_EXT: cover property (@(posedge mclk) en && clk_sel == CLK_EXT && pre_tick);
endmodule : qgpt_channel

// ---- core/qgpt_pkg.sv ----
// ----------------------------------------
// shared constants for the quad timer
// ----------------------------------------
package qgpt_pkg;
    localparam int NUM_CH = 4;               // four channels
    localparam int CNT_W = 16;               // counter width
    localparam int PRE_W = 8;                // prescale field width
    // mode_config field positions
    localparam int MC_W = 16;                // mode_config width
    localparam int MC_RST_POS = 0;           // software channel enable
    localparam int MC_CLK_LSB = 1;           // clock source field, 2 bits
    localparam int MC_FRR_POS = 3;           // free_run_restart_sel: 1 restart
    localparam int MC_ORI_POS = 4;           // reference_irq_enable
    localparam int MC_OM_POS = 5;            // output mode: 0 pulse, 1 toggle
    localparam int MC_CE_LSB = 6;            // capture edge, 2 bits
    localparam int MC_PS_LSB = 8;            // prescale minus one, 8 bits
    localparam logic [MC_W-1:0] MC_RESET = 16'h0000;
    // clock source encodings
    localparam logic [1:0] CLK_STOP = 2'h0;
    localparam logic [1:0] CLK_DIV1 = 2'h1;
    localparam logic [1:0] CLK_DIV16 = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;
    // capture edge encodings
    localparam logic [1:0] CE_OFF = 2'h0;
    localparam logic [1:0] CE_RISE = 2'h1;
    localparam logic [1:0] CE_FALL = 2'h2;
    localparam logic [1:0] CE_ANY = 2'h3;
    localparam int DIV16 = 16;               // main clock divide
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] REF_RESET = 16'hffff;
    localparam int EV_W = 2;                 // event bits
    localparam int EV_CAP = 0;               // capture event
    localparam int EV_REF = 1;               // reference event
    // longest period in main clocks (div16 x 2^8 x 2^16)
    localparam longint MAX_PERIOD = 64'd268435456;
    localparam int SYNC_MIN = 2;             // ext edge delay, main clocks
    localparam int SYNC_MAX = 3;
endpackage : qgpt_pkg

// ---- core/qgpt_top.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Overview of operation
// - four independent 16-bit up counters
// - ch0/1 source: div1, div16, ext pin
// - ch2/3 source: div1 or div16 only
// - ext input synchronised, two-three clocks
// - clock source field in mode_config
// - programmable prescaler advances the counter
// - longest period 268,435,456 main clocks
// - finest resolution is one main clock
// - on reference match, restart or run
// - match sets flag, optional interrupt
// - input capture with selectable edge
// - output compare with selectable behaviour
// - five registers per channel
// ----------------------------------------
module qgpt_top (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [qgpt_pkg::NUM_CH*qgpt_pkg::MC_W-1:0] mode_config,
    input wire logic [qgpt_pkg::NUM_CH*qgpt_pkg::CNT_W-1:0] reference_value,
    input wire logic [qgpt_pkg::NUM_CH*qgpt_pkg::EV_W-1:0] event_clear,
    input wire logic ext_input_zero,
    input wire logic ext_input_one,
    input wire logic [qgpt_pkg::NUM_CH-1:0] cap_in,
    output logic [qgpt_pkg::NUM_CH*qgpt_pkg::CNT_W-1:0] count_value,
    output logic [qgpt_pkg::NUM_CH*qgpt_pkg::CNT_W-1:0] capture_value,
    output logic [qgpt_pkg::NUM_CH*qgpt_pkg::EV_W-1:0] event_flags,
    output logic [qgpt_pkg::NUM_CH-1:0] irq,
    output logic [qgpt_pkg::NUM_CH-1:0] cmp_out
);
    import qgpt_pkg::*;

    // ----------------------------------------
    // reset release, two flops
    // ----------------------------------------
    logic rst_s1_ff, rst_n_ff;               // reset sync chain
    logic [3:0] div_ff;                      // shared divide-by-16 counter
    logic div16_tick;                        // one clock in sixteen
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff <= rst_s1_ff;
        end
    end

    // shared so every channel on div16 ticks in step
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end
    assign div16_tick = (div_ff == 4'(DIV16 - 1));

    // ----------------------------------------
    // channels; each holds its five registers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic ext_pin;
            assign ext_pin = (g == 0) ? ext_input_zero : ((g == 1) ? ext_input_one : 1'b0);
            qgpt_channel #(.HAS_EXT(g < 2)) u_ch (
                .mclk(mclk),
                .rst_n(rst_n_ff),
                .div16_tick(div16_tick),
                .mode_config(mode_config[g*MC_W +: MC_W]),
                .reference_value(reference_value[g*CNT_W +: CNT_W]),
                .ext_in(ext_pin),
                .cap_in(cap_in[g]),
                .event_clear(event_clear[g*EV_W +: EV_W]),
                .count_value(count_value[g*CNT_W +: CNT_W]),
                .capture_value(capture_value[g*CNT_W +: CNT_W]),
                .event_flags(event_flags[g*EV_W +: EV_W]),
                .irq(irq[g]),
                .cmp_out(cmp_out[g])
            );
        end
    endgenerate
endmodule : qgpt_top

// ---- tb/qgpt_pin_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// pin side: external clocks and capture pins
// ----------------------------------------
module qgpt_pin_model #(
    parameter int HI = 4 // high time of one ext pulse, slow for the sync
) (
    input wire logic mclk,
    input wire logic [1:0] tick_req,
    input wire logic [3:0] cap_lvl,
    output logic ext_input_zero,
    output logic ext_input_one,
    output logic [3:0] cap_in
);
    int hold [2]; // remaining high cycles per ext pin
    // one request gives one clean rising edge on that pin
    always @(posedge mclk) begin
        for (int i = 0; i < 2; i++) begin
            if (tick_req[i]) begin
                hold[i] <= HI;
            end else if (hold[i] > 0) begin
                hold[i] <= hold[i] - 1;
            end
        end
    end
    assign ext_input_zero = (hold[0] > 0);
    assign ext_input_one = (hold[1] > 0);
    // capture pins are plain levels set by the bench
    assign cap_in = cap_lvl;
endmodule : qgpt_pin_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import qgpt_pkg::*;
    logic mclk, resetn, ext0, ext1;
    logic [NUM_CH*MC_W-1:0] mode_config;
    logic [NUM_CH*CNT_W-1:0] reference_value, count_value, capture_value;
    logic [NUM_CH*EV_W-1:0] event_clear, event_flags;
    logic [3:0] cap_lvl, cap_in, irq, cmp_out;
    logic [1:0] tick_req;
    int n_fail, tests_run;
    // ----------------------------------------
    // instances
    // ----------------------------------------
    qgpt_top dut (.mclk(mclk), .resetn(resetn), .mode_config(mode_config),
        .reference_value(reference_value), .event_clear(event_clear),
        .ext_input_zero(ext0), .ext_input_one(ext1), .cap_in(cap_in),
        .count_value(count_value), .capture_value(capture_value),
        .event_flags(event_flags), .irq(irq), .cmp_out(cmp_out));
    qgpt_pin_model pins (.mclk(mclk), .tick_req(tick_req), .cap_lvl(cap_lvl),
        .ext_input_zero(ext0), .ext_input_one(ext1), .cap_in(cap_in));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // inputs always move 1 ns after the edge
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    function automatic logic [15:0] cnt(input int ch);
        return count_value[ch*CNT_W+:CNT_W];
    endfunction : cnt
    function automatic logic [15:0] fl(input int ch);
        return {14'h0000, event_flags[ch*EV_W+:EV_W]};
    endfunction : fl
    // enabled channel word from its fields
    function automatic logic [15:0] mc(input logic [1:0] src, input logic free_run_restart_sel, reference_irq_enable, om,
                                       input logic [1:0] ce, input logic [7:0] ps);
        return {ps, ce, om, reference_irq_enable, free_run_restart_sel, src, 1'b1};
    endfunction : mc
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task cfg(input int ch, input logic [15:0] m, input logic [15:0] r);
        mode_config[ch*MC_W+:MC_W] = m;
        reference_value[ch*CNT_W+:CNT_W] = r;
    endtask : cfg
    // disable channel and clear both flags in the same cycle
    task off(input int ch);
        mode_config[ch*MC_W+:MC_W] = MC_RESET;
        event_clear[ch*EV_W+:EV_W] = 2'h3;
        tick(1);
        event_clear[ch*EV_W+:EV_W] = 2'h0;
        tick(1);
    endtask : off
    // bounded wait for a count value
    task wait_cnt(input int ch, input logic [15:0] v);
        int k;
        k = 0;
        while (cnt(ch) !== v && k < 3000) begin
            tick(1);
            k++;
        end
        if (k == 3000) chk(cnt(ch), v);
    endtask : wait_cnt
    // one ext edge, then enough low time
    task ext_pulse(input int ch);
        tick_req[ch] = 1'b1;
        tick(1);
        tick_req[ch] = 1'b0;
        tick(10);
    endtask : ext_pulse
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_restart;
        cfg(0, mc(CLK_DIV1, 1'b1, 1'b1, 1'b0, CE_OFF, 8'h00), 16'h0002);
        wait_cnt(0, 16'h0002);
        tick(1);
        chk(cnt(0), 16'h0000);
        chk(fl(0), 16'h0002);
        chk({15'h0000, irq[0]}, 16'h0001);
        chk({15'h0000, cmp_out[0]}, 16'h0001);
        off(0);
        chk(fl(0), 16'h0000);
        $display("test restart done");
    endtask : t_restart
    task t_freerun;
        cfg(1, mc(CLK_DIV1, 1'b0, 1'b0, 1'b0, CE_OFF, 8'h00), 16'h0003);
        wait_cnt(1, 16'h0003);
        tick(1);
        chk(cnt(1), 16'h0004);
        chk(fl(1), 16'h0002);
        chk({15'h0000, irq[1]}, 16'h0000);
        off(1);
        $display("test freerun done");
    endtask : t_freerun
    task t_prescale;
        cfg(2, mc(CLK_DIV1, 1'b0, 1'b0, 1'b0, CE_OFF, 8'h03), 16'hffff);
        wait_cnt(2, 16'h0001);
        tick(3);
        chk(cnt(2), 16'h0001);
        tick(1);
        chk(cnt(2), 16'h0002);
        cfg(3, mc(CLK_DIV16, 1'b0, 1'b0, 1'b0, CE_OFF, 8'h00), 16'hffff);
        wait_cnt(3, 16'h0001);
        tick(DIV16 - 1);
        chk(cnt(3), 16'h0001);
        tick(1);
        chk(cnt(3), 16'h0002);
        off(2);
        off(3);
        cfg(3, mc(CLK_EXT, 1'b0, 1'b0, 1'b0, CE_OFF, 8'h00), 16'hffff);
        tick(40);
        chk(cnt(3), 16'h0000);
        off(3);
        $display("test prescale done");
    endtask : t_prescale
    task t_ext;
        for (int ch = 0; ch < 2; ch++) begin
            cfg(ch, mc(CLK_EXT, 1'b0, 1'b0, 1'b0, CE_OFF, 8'h00), 16'hffff);
            tick(2);
            tick_req[ch] = 1'b1;
            tick(1);
            tick_req[ch] = 1'b0;
            tick(1);
            chk(cnt(ch), 16'h0000);
            tick(4);
            chk(cnt(ch), 16'h0001);
            tick(6);
            ext_pulse(ch);
            chk(cnt(ch), 16'h0002);
            off(ch);
        end
        $display("test ext done");
    endtask : t_ext
    task t_capture;
        cfg(1, mc(CLK_EXT, 1'b0, 1'b0, 1'b1, CE_RISE, 8'h00), 16'h0002);
        ext_pulse(1);
        ext_pulse(1);
        chk(cnt(1), 16'h0002);
        chk({15'h0000, cmp_out[1]}, 16'h0001);
        cap_lvl[1] = 1'b1;
        tick(3);
        chk(capture_value[CNT_W+:CNT_W], 16'h0002);
        chk(fl(1), 16'h0003);
        // switch to falling edge while the pin stays high, so no edge hides in the clear
        event_clear[EV_W+:EV_W] = 2'h3;
        mode_config[MC_W+MC_CE_LSB+:2] = CE_FALL;
        tick(1);
        event_clear[EV_W+:EV_W] = 2'h0;
        cap_lvl[1] = 1'b0;
        tick(3);
        chk(fl(1), 16'h0001);
        event_clear[EV_W+:EV_W] = 2'h3;
        tick(1);
        event_clear[EV_W+:EV_W] = 2'h0;
        cap_lvl[1] = 1'b1;
        tick(3);
        chk(fl(1), 16'h0000);
        off(1);
        $display("test capture done");
    endtask : t_capture
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task test_done;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    // watchdog: whole run needs well under 1000 cycles
    initial begin
        #20000;
        n_fail++;
        test_done;
    end
    initial begin
        resetn = 1'b0;
        mode_config = '0;
        reference_value = '0;
        event_clear = '0;
        cap_lvl = 4'h0;
        tick_req = 2'h0;
        repeat (2) @(posedge mclk);
        #1;
        resetn = 1'b1;
        tick(4);
        t_restart;
        t_freerun;
        t_prescale;
        t_ext;
        t_capture;
        test_done;
    end
endmodule : testbench
